// ===== design/fifo_queue_defines.vh
// Constants for the configurable FIFO queue: sizes, register map, fields, resets, timing.
`ifndef FIFO_QUEUE_DEFINES_VH
`define FIFO_QUEUE_DEFINES_VH

// Storage geometry.
`define FQ_DW 32
`define FQ_AW 10
`define FQ_DEPTH 1024
`define FQ_RATIO 1
`define FQ_FULL_CNT 11'h400
`define FQ_AFULL_CNT 11'h3ff
`define FQ_ZERO_CNT 11'h000
`define FQ_AEMPTY_CNT 12'h001

// Reset sequence length in clock cycles.
`define FQ_RST_CYCLES 3'h4

// Register byte offsets on the Wishbone slave.
`define FQ_REG_CTRL 8'h00
`define FQ_REG_PFULL 8'h04
`define FQ_REG_PEMPTY 8'h08
`define FQ_REG_STATUS 8'h0c
`define FQ_REG_COUNT 8'h10

// Control register fields.
`define FQ_CTRL_SA 0
`define FQ_CTRL_ASYNC 1
`define FQ_EN_AFULL 2
`define FQ_EN_PFULL 3
`define FQ_EN_ACK 4
`define FQ_EN_OVF 5
`define FQ_EN_AEMPTY 6
`define FQ_EN_PEMPTY 7
`define FQ_EN_VALID 8
`define FQ_EN_UDF 9

// Register reset values.
`define FQ_CTRL_RST 32'h0000_03fc
`define FQ_PFULL_RST 32'h03f8_03fc
`define FQ_PEMPTY_RST 32'h0008_0004

`endif

// ===== design/configurable_fifo_queue.v
// Configurable FIFO queue with flags, counts, show-ahead mode and a Wishbone control slave.
//
// How it works
// - Reset clears both pointers and returns every flag to its reset state.
// - A reset-busy output stays high while the internal reset sequence runs.
// - Write side and read side logic are both timed by the one clock clk_i.
// - Separate write-side and read-side word counts are output, log2 of depth wide.
// - A single stored-word count is output for the symmetric ratio.
// - An enabled write while not full stores the write-data word.
// - Writes while full are ignored; contents and pointers stay untouched.
// - Almost-full shows when exactly one more write fits.
// - Programmable full sets at count >= assert level, clears below negate level.
// - Write acknowledge pulses one cycle after an accepted write.
// - Overflow pulses one cycle after a write refused for fullness.
// - An enabled read while not empty removes the oldest word onto read data.
// - Reads while empty are ignored without harming contents or pointers.
// - Almost-empty shows when exactly one word remains.
// - Programmable empty sets at count <= assert level, clears above negate level.
// - Read-valid marks a valid word on the read-data bus.
// - Underflow pulses one cycle after a read refused for emptiness.
// - Word width and depth are set by constants, width 1-256, depth up to 131072.
// - Read width follows write width and the port ratio.
// - Each optional output has its own enable; full and empty are unaffected.
// - In show-ahead mode, with the decoupled crossing off, the first word appears one cycle after its write.
// - Own-side flags react at once; far-side flags at once too, or after one plus two cycles in the decoupled mode.
// - Every port is sampled and updated on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_queue_defines.vh"

module configurable_fifo_queue (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    input wire wr_en_i,
    input wire [`FQ_DW-1:0] wdata_i,
    output wire full_o,
    output wire almost_full_o,
    output wire prog_full_o,
    output wire wr_ack_o,
    output wire overflow_o,
    input wire rd_en_i,
    output wire [`FQ_DW-1:0] rdata_o,
    output wire empty_o,
    output wire almost_empty_o,
    output wire prog_empty_o,
    output wire rd_valid_o,
    output wire underflow_o,
    output wire [`FQ_AW-1:0] datacount_o,
    output wire [`FQ_AW-1:0] wr_datacount_o,
    output wire [`FQ_AW-1:0] rd_datacount_o,
    output wire rst_busy_o
);

    // Storage array; a plain array so synthesis may map it into block RAM.
    reg [`FQ_DW-1:0] mem [0:`FQ_DEPTH-1];

    reg [`FQ_AW:0] wptr_r;
    reg [`FQ_AW:0] rptr_r;
    reg [`FQ_AW:0] wgray_r;
    reg [`FQ_AW:0] wsync1_r;
    reg [`FQ_AW:0] wsync2_r;
    reg [`FQ_AW:0] rgray_r;
    reg [`FQ_AW:0] rsync1_r;
    reg [`FQ_AW:0] rsync2_r;
    reg busy_r;
    reg [2:0] busy_cnt_r;
    reg [31:0] ctrl_r;
    reg [31:0] pf_thr_r;
    reg [31:0] pe_thr_r;
    reg [`FQ_DW-1:0] rdata_r;
    reg sa_valid_r;
    reg std_valid_r;
    reg wack_r;
    reg ovf_r;
    reg udf_r;
    reg pfull_r;
    reg pempty_r;
    reg wb_ack_r;
    reg [31:0] wb_dat_r;
    reg [31:0] reg_rd;

    // Binary to Gray: only one bit changes per step, so a sampled pointer is never torn.
    function [`FQ_AW:0] bin2gray;
        input [`FQ_AW:0] b;
        begin
            bin2gray = b ^ (b >> 1);
        end
    endfunction

    // Gray back to binary, folding from the top bit down.
    function [`FQ_AW:0] gray2bin;
        input [`FQ_AW:0] g;
        integer i;
        begin
            gray2bin[`FQ_AW] = g[`FQ_AW];
            for (i = `FQ_AW - 1; i >= 0; i = i - 1) begin
                gray2bin[i] = gray2bin[i + 1] ^ g[i];
            end
        end
    endfunction

    // Byte-lane merge so that wb_sel_i masks which bytes a write updates.
    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0] sel;
        integer i;
        begin
            merge = old_v;
            for (i = 0; i < 4; i = i + 1) begin
                if (sel[i]) begin
                    merge[i*8 +: 8] = new_v[i*8 +: 8];
                end
            end
        end
    endfunction

    wire sa_mode = ctrl_r[`FQ_CTRL_SA];
    wire async_mode = ctrl_r[`FQ_CTRL_ASYNC];

    // Each side sees its own pointer at once and the far pointer either directly
    // or, in the decoupled mode, after one register plus two synchroniser stages.
    wire [`FQ_AW:0] rptr_seen_w = async_mode ? gray2bin(rsync2_r) : rptr_r;
    wire [`FQ_AW:0] wptr_seen_r = async_mode ? gray2bin(wsync2_r) : wptr_r;
    wire [`FQ_AW:0] wcount = wptr_r - rptr_seen_w;
    wire [`FQ_AW:0] core_cnt = wptr_seen_r - rptr_r;
    wire sa_hold = sa_mode & sa_valid_r;
    wire [`FQ_AW+1:0] rcount = {1'b0, core_cnt} + {{(`FQ_AW+1){1'b0}}, sa_hold};

    // Both flags read as set during reset so no request can slip in.
    wire full_int = busy_r | (wcount == `FQ_FULL_CNT);
    wire empty_int = busy_r | (sa_mode ? ~sa_valid_r : (core_cnt == `FQ_ZERO_CNT));

    wire wr_go = wr_en_i & ~full_int;
    wire wr_refused = wr_en_i & full_int & ~busy_r;
    wire rd_go = rd_en_i & ~empty_int;
    wire rd_refused = rd_en_i & empty_int & ~busy_r;

    // Show-ahead refill: load the output stage when it is empty or being consumed.
    wire sa_load = sa_mode & ~busy_r & (~sa_valid_r | rd_go);
    wire sa_from_mem = sa_load & (core_cnt != `FQ_ZERO_CNT);
    wire sa_bypass = sa_load & (core_cnt == `FQ_ZERO_CNT) & ~async_mode & wr_go;
    wire rd_take = sa_mode ? (sa_from_mem | sa_bypass) : rd_go;

    // Storage write; a refused write never touches the array.
    always @(posedge clk_i) begin
        if (wr_go) begin
            mem[wptr_r[`FQ_AW-1:0]] <= wdata_i;
        end
    end

    // Write pointer, advanced only by accepted writes.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wptr_r <= {(`FQ_AW+1){1'b0}};
        end else if (wr_go) begin
            wptr_r <= wptr_r + 1'b1;
        end
    end

    // Read pointer, advanced by a standard read or a show-ahead refill.
    always @(posedge clk_i) begin
        if (rst_i) begin
            rptr_r <= {(`FQ_AW+1){1'b0}};
        end else if (rd_take) begin
            rptr_r <= rptr_r + 1'b1;
        end
    end

    // Pointer crossing: Gray register in the source side, then two plain stages.
    // Only the second stage is decoded; the first is never looked at directly.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wgray_r <= {(`FQ_AW+1){1'b0}};
            wsync1_r <= {(`FQ_AW+1){1'b0}};
            wsync2_r <= {(`FQ_AW+1){1'b0}};
            rgray_r <= {(`FQ_AW+1){1'b0}};
            rsync1_r <= {(`FQ_AW+1){1'b0}};
            rsync2_r <= {(`FQ_AW+1){1'b0}};
        end else begin
            wgray_r <= bin2gray(wptr_r);
            wsync1_r <= wgray_r;
            wsync2_r <= wsync1_r;
            rgray_r <= bin2gray(rptr_r);
            rsync1_r <= rgray_r;
            rsync2_r <= rsync1_r;
        end
    end

    // Reset sequence: holds the queue closed for a fixed number of cycles.
    always @(posedge clk_i) begin
        if (rst_i) begin
            busy_r <= 1'b1;
            busy_cnt_r <= `FQ_RST_CYCLES;
        end else if (busy_r) begin
            busy_cnt_r <= busy_cnt_r - 1'b1;
            if (busy_cnt_r == 3'h1) begin
                busy_r <= 1'b0;
            end
        end
    end

    // Read data register: standard mode fetches on the read, show-ahead prefetches.
    always @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= {`FQ_DW{1'b0}};
        end else if (sa_from_mem) begin
            rdata_r <= mem[rptr_r[`FQ_AW-1:0]];
        end else if (sa_bypass) begin
            rdata_r <= wdata_i;
        end else if (~sa_mode & rd_go) begin
            rdata_r <= mem[rptr_r[`FQ_AW-1:0]];
        end
    end

    // Valid tracking for both read modes.
    always @(posedge clk_i) begin
        if (rst_i) begin
            sa_valid_r <= 1'b0;
            std_valid_r <= 1'b0;
        end else begin
            std_valid_r <= ~sa_mode & rd_go;
            if (sa_load) begin
                sa_valid_r <= sa_from_mem | sa_bypass;
            end else if (~sa_mode) begin
                sa_valid_r <= 1'b0;
            end
        end
    end

    // Handshake pulses, each one cycle after the request that caused it.
    always @(posedge clk_i) begin
        if (rst_i) begin
            wack_r <= 1'b0;
            ovf_r <= 1'b0;
            udf_r <= 1'b0;
        end else begin
            wack_r <= wr_go;
            ovf_r <= wr_refused;
            udf_r <= rd_refused;
        end
    end

    // Programmable flags with hysteresis; the gap between levels stops chatter.
    always @(posedge clk_i) begin
        if (rst_i) begin
            pfull_r <= 1'b0;
            pempty_r <= 1'b1;
        end else begin
            if ({5'h00, wcount} >= pf_thr_r[15:0]) begin
                pfull_r <= 1'b1;
            end else if ({5'h00, wcount} < pf_thr_r[31:16]) begin
                pfull_r <= 1'b0;
            end
            if ({4'h0, rcount} <= pe_thr_r[15:0]) begin
                pempty_r <= 1'b1;
            end else if ({4'h0, rcount} > pe_thr_r[31:16]) begin
                pempty_r <= 1'b0;
            end
        end
    end

    // Wishbone classic slave: answers every request one cycle later, then drops ack.
    wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;

    // Register read mux; unmapped offsets read as zero.
    always @* begin
        case (wb_adr_i)
            `FQ_REG_CTRL: begin
                reg_rd = ctrl_r;
            end
            `FQ_REG_PFULL: begin
                reg_rd = pf_thr_r;
            end
            `FQ_REG_PEMPTY: begin
                reg_rd = pe_thr_r;
            end
            `FQ_REG_STATUS: begin
                reg_rd = {20'h00000, busy_r, udf_r, ovf_r, rd_valid_o, pempty_r, pfull_r,
                          almost_empty_o, almost_full_o, empty_int, full_int, 2'h0};
            end
            `FQ_REG_COUNT: begin
                reg_rd = {4'h0, rcount, 5'h00, wcount};
            end
            default: begin
                reg_rd = 32'h0000_0000;
            end
        endcase
    end

    // Register writes take effect on the edge where ack is raised.
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= `FQ_CTRL_RST;
            pf_thr_r <= `FQ_PFULL_RST;
            pe_thr_r <= `FQ_PEMPTY_RST;
            wb_ack_r <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else begin
            wb_ack_r <= wb_req;
            if (wb_req) begin
                wb_dat_r <= reg_rd;
            end
            if (wb_req & wb_we_i) begin
                case (wb_adr_i)
                    `FQ_REG_CTRL: begin
                        ctrl_r <= merge(ctrl_r, wb_dat_i, wb_sel_i) & `FQ_CTRL_RST | 
                                  merge(ctrl_r, wb_dat_i, wb_sel_i) & 32'h0000_0003;
                    end
                    `FQ_REG_PFULL: begin
                        pf_thr_r <= merge(pf_thr_r, wb_dat_i, wb_sel_i);
                    end
                    `FQ_REG_PEMPTY: begin
                        pe_thr_r <= merge(pe_thr_r, wb_dat_i, wb_sel_i);
                    end
                    default: begin
                        ctrl_r <= ctrl_r;
                    end
                endcase
            end
        end
    end

    assign wb_ack_o = wb_ack_r;
    assign wb_dat_o = wb_dat_r;

    // Mandatory flags ignore the option enables entirely.
    assign full_o = full_int;
    assign empty_o = empty_int;

    // Optional outputs, each gated by its own enable bit.
    assign almost_full_o = ctrl_r[`FQ_EN_AFULL] & ~busy_r & (wcount == `FQ_AFULL_CNT);
    assign prog_full_o = ctrl_r[`FQ_EN_PFULL] & pfull_r;
    assign wr_ack_o = ctrl_r[`FQ_EN_ACK] & wack_r;
    assign overflow_o = ctrl_r[`FQ_EN_OVF] & ovf_r;
    assign almost_empty_o = ctrl_r[`FQ_EN_AEMPTY] & ~busy_r & (rcount == `FQ_AEMPTY_CNT);
    assign prog_empty_o = ctrl_r[`FQ_EN_PEMPTY] & pempty_r;
    assign rd_valid_o = ctrl_r[`FQ_EN_VALID] & (sa_mode ? sa_valid_r : std_valid_r);
    assign underflow_o = ctrl_r[`FQ_EN_UDF] & udf_r;

    // Read width equals write width times the configured ratio, here one to one.
    assign rdata_o = rdata_r;

    // Counts are log2(depth) wide, so a completely full queue wraps to zero.
    assign datacount_o = rcount[`FQ_AW-1:0];
    assign wr_datacount_o = wcount[`FQ_AW-1:0];
    assign rd_datacount_o = rcount[`FQ_AW-1:0];
    assign rst_busy_o = busy_r;

endmodule

`default_nettype wire

// ===== verification/queue_checker_assertions.sv
// Port-level checker for the queue handshakes, flags, counts and register bus.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_queue_defines.vh"
module queue_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic full_o,
    input wire logic empty_o,
    input wire logic almost_full_o,
    input wire logic almost_empty_o,
    input wire logic wr_ack_o,
    input wire logic overflow_o,
    input wire logic underflow_o,
    input wire logic rst_busy_o,
    input wire logic [`FQ_AW-1:0] wr_datacount_o,
    input wire logic [`FQ_AW-1:0] rd_datacount_o
);
    // One clock domain, so clock and reset are given once.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // The busy window after release has a fixed length.
    sequence s_busy_hold;
        rst_busy_o [*4];
    endsequence
    sequence s_busy_end;
        ##1 !rst_busy_o;
    endsequence
    property p_busy; $fell(rst_i) |-> s_busy_hold ##0 s_busy_end; endproperty
    property p_busy_flags; rst_busy_o |-> full_o && empty_o; endproperty
    property p_wr_ack; wr_ack_o |-> $past(wr_en_i && !full_o); endproperty
    property p_ovf; overflow_o |-> $past(wr_en_i && full_o); endproperty
    property p_udf; underflow_o |-> $past(rd_en_i && empty_o); endproperty
    property p_full_hold;
        wr_en_i && full_o && !rd_en_i |=> $stable(wr_datacount_o);
    endproperty
    // A write into an empty show-ahead queue, decoupled crossing off, lands in the output stage, which the
    // write-side count leaves out, so only writes behind a held word are counted here.
    property p_wr_cnt;
        wr_en_i && !full_o && !rd_en_i && !empty_o |=>
            wr_datacount_o == $past(wr_datacount_o) + 1'b1;
    endproperty
    property p_afull; almost_full_o |-> wr_datacount_o == 10'h3ff && !full_o; endproperty
    property p_aempty; almost_empty_o |-> rd_datacount_o == 10'h001 && !empty_o; endproperty
    property p_wb_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    property p_wb_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_busy: assert property (p_busy) else $error("busy window length wrong");
    a_busy_flags: assert property (p_busy_flags) else $error("flags not held");
    a_wr_ack: assert property (p_wr_ack) else $error("write ack without write");
    a_ovf: assert property (p_ovf) else $error("overflow without cause");
    a_udf: assert property (p_udf) else $error("underflow without cause");
    a_full_hold: assert property (p_full_hold) else $error("full write moved count");
    a_wr_cnt: assert property (p_wr_cnt) else $error("write count not stepped");
    a_afull: assert property (p_afull) else $error("almost full at wrong count");
    a_aempty: assert property (p_aempty) else $error("almost empty wrong count");
    a_wb_ack: assert property (p_wb_ack) else $error("bus ack late");
    a_wb_pulse: assert property (p_wb_pulse) else $error("bus ack too long");
endmodule
`default_nettype wire

// ===== verification/queue_user.sv
// User-side producer and consumer model with an in-order scoreboard.
`timescale 1ns/1ps
`default_nettype none
module queue_user (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wr_go_i,
    input wire logic rd_go_i,
    input wire logic sa_i,
    input wire logic full_i,
    input wire logic rd_valid_i,
    input wire logic [31:0] rdata_i,
    output logic wr_en_o,
    output logic [31:0] wdata_o,
    output logic rd_en_o,
    output logic [15:0] seen_o,
    output logic [15:0] bad_o
);
    logic [31:0] seq_r, exp_r, seq_nxt;
    logic pop;
    // A word counts as sent only when the queue could take it.
    assign seq_nxt = seq_r + {31'h0, wr_en_o && !full_i};
    // Standard mode pops on valid; show-ahead pops on a read while valid.
    assign pop = sa_i ? (rd_en_o && rd_valid_i) : rd_valid_i;
    // Idle data is inverted each cycle so stale words never pass for new ones.
    always @(posedge clk_i) begin
        if (rst_i) begin
            seq_r <= 32'h0;
            exp_r <= 32'h0;
            seen_o <= 16'h0;
            bad_o <= 16'h0;
            wr_en_o <= 1'b0;
            rd_en_o <= 1'b0;
            wdata_o <= 32'h5a5a_a5a5;
        end else begin
            seq_r <= seq_nxt;
            wr_en_o <= wr_go_i;
            wdata_o <= wr_go_i ? seq_nxt : ~wdata_o;
            rd_en_o <= rd_go_i;
            if (pop) begin
                seen_o <= seen_o + 16'h1;
                exp_r <= exp_r + 32'h1;
                bad_o <= bad_o + {15'h0, rdata_i !== exp_r};
            end
        end
    end
endmodule
`default_nettype wire

// ===== verification/configurable_fifo_queue_test.sv
// Self-checking bench for the configurable queue.
`timescale 1ns/1ps
`default_nettype none
`include "fifo_queue_defines.vh"
module configurable_fifo_queue_test;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wr_go = 1'b0, rd_go = 1'b0;
    logic sa = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rdata_o, wdata_i, rd_q;
    logic wb_ack_o, wr_en_i, rd_en_i, full_o, almost_full_o, prog_full_o, wr_ack_o;
    logic overflow_o, empty_o, almost_empty_o, prog_empty_o, rd_valid_o, underflow_o;
    logic rst_busy_o;
    logic [`FQ_AW-1:0] datacount_o, wr_datacount_o, rd_datacount_o;
    logic [15:0] seen, bad;
    integer err_count = 0, n_tests = 0;
    configurable_fifo_queue u_configurable_fifo_queue (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wr_en_i, .wdata_i,
        .full_o, .almost_full_o, .prog_full_o, .wr_ack_o, .overflow_o, .rd_en_i, .rdata_o,
        .empty_o, .almost_empty_o, .prog_empty_o, .rd_valid_o, .underflow_o, .datacount_o,
        .wr_datacount_o, .rd_datacount_o, .rst_busy_o);
    queue_user u_queue_user (.clk_i, .rst_i, .wr_go_i(wr_go), .rd_go_i(rd_go), .sa_i(sa),
        .full_i(full_o), .rd_valid_i(rd_valid_o), .rdata_i(rdata_o), .wr_en_o(wr_en_i),
        .wdata_o(wdata_i), .rd_en_o(rd_en_i), .seen_o(seen), .bad_o(bad));
    // Free-running 125 MHz clock.
    always #4 clk_i = ~clk_i;
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // A wait that runs out ends the run at once.
    task automatic to(input string nm);
        err_count++;
        $display("mismatch %s expected done seen timeout", nm);
        final_report;
    endtask
    // Classic cycle: the request stands until the edge where ack is seen high,
    // read data is taken at that edge and only then is the request released.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        integer i;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        i = 0;
        do begin
            @(posedge clk_i);
            i++;
        end while (wb_ack_o !== 1'b1 && i < 20);
        if (wb_ack_o !== 1'b1) to("wb_ack");
        rd_q = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
        wb(1'b0, a, 32'h0, 4'hf);
        chk(nm, ex, rd_q);
    endtask
    task automatic t_reset;
        integer i;
        @(posedge clk_i);
        rst_i <= 1'b1;
        sa <= 1'b0;
        repeat (16) @(posedge clk_i);
        @(negedge clk_i);
        chk("rst_flags", 32'h7, {29'h0, full_o, empty_o, rst_busy_o});
        @(posedge clk_i);
        rst_i <= 1'b0;
        i = 0;
        do begin
            @(negedge clk_i);
            i++;
        end while (rst_busy_o === 1'b1 && i < 20);
        chk("busy_len", 32'h5, i);
        chk("idle_flags", 32'h1, {30'h0, full_o, empty_o});
        chk("idle_count", 32'h0, {22'h0, datacount_o});
        $display("test reset done");
    endtask
    task automatic t_regs;
        rd_chk("ctrl", `FQ_REG_CTRL, `FQ_CTRL_RST);
        rd_chk("pfull", `FQ_REG_PFULL, `FQ_PFULL_RST);
        rd_chk("pempty", `FQ_REG_PEMPTY, `FQ_PEMPTY_RST);
        wb(1'b1, `FQ_REG_STATUS, 32'hffff_ffff, 4'hf);
        rd_chk("status", `FQ_REG_STATUS, 32'h0000_0088);
        wb(1'b1, 8'h14, 32'hffff_ffff, 4'hf);
        rd_chk("unmapped", 8'h14, 32'h0);
        $display("test regs done");
    endtask
    task automatic t_fill;
        integer i;
        @(posedge clk_i);
        wr_go <= 1'b1;
        for (i = 0; i < 1100 && full_o !== 1'b1; i++) begin
            @(negedge clk_i);
            case (wr_datacount_o)
                10'h001: chk("aempty", 32'h1, {31'h0, almost_empty_o});
                10'h200: chk("wr_ack", 32'h1, {31'h0, wr_ack_o});
                10'h3fb: chk("pfull_lo", 32'h0, {31'h0, prog_full_o});
                10'h3fd: chk("pfull_hi", 32'h1, {31'h0, prog_full_o});
                10'h3ff: chk("afull", 32'h1, {31'h0, almost_full_o});
                default: ;
            endcase
        end
        if (full_o !== 1'b1) to("fill");
        @(posedge clk_i);
        wr_go <= 1'b0;
        @(negedge clk_i);
        chk("overflow", 32'h1, {31'h0, overflow_o});
        chk("full_count", 32'h0, {22'h0, datacount_o});
        $display("test fill done");
    endtask
    task automatic t_drain;
        integer i;
        @(posedge clk_i);
        rd_go <= 1'b1;
        for (i = 0; i < 1100 && empty_o !== 1'b1; i++) begin
            @(negedge clk_i);
            if (rd_datacount_o == 10'h200) chk("pe_lo", 32'h0, {31'h0, prog_empty_o});
            if (rd_datacount_o == 10'h003) chk("pe_hi", 32'h1, {31'h0, prog_empty_o});
        end
        if (empty_o !== 1'b1) to("drain");
        @(posedge clk_i);
        rd_go <= 1'b0;
        @(negedge clk_i);
        chk("underflow", 32'h2, {30'h0, underflow_o, rd_valid_o});
        repeat (3) @(negedge clk_i);
        chk("order", 32'h0400_0000, {seen, bad});
        $display("test drain done");
    endtask
    task automatic t_show;
        wb(1'b1, `FQ_REG_CTRL, 32'hffff_fffd, 4'h1);
        rd_chk("ctrl_sel", `FQ_REG_CTRL, 32'h0000_03fd);
        sa <= 1'b1;
        @(posedge clk_i);
        wr_go <= 1'b1;
        @(posedge clk_i);
        wr_go <= 1'b0;
        @(negedge clk_i);
        chk("sa_before", 32'h1, {31'h0, empty_o});
        @(negedge clk_i);
        chk("sa_flags", 32'h2, {30'h0, rd_valid_o, empty_o});
        chk("sa_data", 32'h0000_0400, rdata_o);
        @(posedge clk_i);
        rd_go <= 1'b1;
        @(posedge clk_i);
        rd_go <= 1'b0;
        repeat (2) @(negedge clk_i);
        chk("sa_pop", 32'h0401_0001, {seen, 15'h0, empty_o});
        $display("test show_ahead done");
    endtask
    task automatic t_opts;
        wb(1'b1, `FQ_REG_CTRL, 32'h0000_0002, 4'hf);
        sa <= 1'b0;
        @(posedge clk_i);
        wr_go <= 1'b1;
        @(posedge clk_i);
        wr_go <= 1'b0;
        // Decoupled crossing: the own count moves at once, the far side lags three edges.
        repeat (2) @(negedge clk_i);
        chk("async_own", 32'h1, {22'h0, wr_datacount_o});
        chk("async_far", 32'h1, {31'h0, empty_o});
        repeat (2) @(negedge clk_i);
        chk("async_lag", 32'h1, {31'h0, empty_o});
        @(negedge clk_i);
        chk("opt_off", 32'h0, {almost_empty_o, prog_empty_o, rd_valid_o, empty_o});
        chk("opt_count", 32'h1, {22'h0, datacount_o});
        chk("opt_bad", 32'h0, {16'h0, bad});
        $display("test options done");
    endtask
    initial begin
        t_reset;
        t_regs;
        t_fill;
        t_drain;
        t_show;
        t_opts;
        t_reset;
        final_report;
    end
endmodule
bind configurable_fifo_queue queue_checker u_queue_checker (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .wr_en_i, .rd_en_i, .full_o, .empty_o, .almost_full_o,
    .almost_empty_o, .wr_ack_o, .overflow_o, .underflow_o, .rst_busy_o, .wr_datacount_o,
    .rd_datacount_o);
`default_nettype wire
